// ---- inc/ssnc_pkg.sv ----
// shared constants and types for the serial shadow nvram control block
package ssnc_pkg;

   // -------------------------------------------------------------
   // array geometry
   // -------------------------------------------------------------
   localparam int WORDS = 16;           // words in ram and nv array
   localparam int WORD_BITS = 16;       // bits per word
   localparam int ADDR_BITS = 4;        // word address width
   localparam int INSTR_BITS = 7;       // address plus opcode after marker
   localparam logic [2:0] INSTR_LAST = 3'h6; // index of last instruction bit
   localparam logic [4:0] PUSH_END = 5'h10;  // push index once all words queued
   localparam int FIFO_DEPTH = 32;      // store queue depth

   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int CLK_MHZ = 250;        // system clock rate
   localparam int STORE_TIME_MS = 10;   // longest store time
   // longest time, so rounded down
   localparam int STORE_CYC = STORE_TIME_MS * 1000 * CLK_MHZ;
   localparam int STORE_FILT_NS = 100;  // least store pin low time
   // least time, so rounded up
   localparam int STORE_FILT_CYC_I = (STORE_FILT_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] STORE_FILT_CYC = 8'(STORE_FILT_CYC_I);
   localparam int DRAIN_DIV_BITS = 6;   // nv word write every 64 cycles

   // -------------------------------------------------------------
   // opcodes (last three instruction bits)
   // -------------------------------------------------------------
   localparam logic [2:0] OPC_WRITE = 3'h3;
   localparam logic [2:0] OPC_RECALL = 3'h5;
   localparam logic [2:0] OPC_STORE = 3'h1;
   localparam logic [2:0] OPC_SLEEP = 3'h2;
   localparam logic [2:0] OPC_WREN = 3'h4;
   localparam logic [2:0] OPC_WRDIS = 3'h0;
   localparam logic [1:0] OPC_READ_HI = 2'h3; // read is 11x

   typedef enum logic [2:0] {
      OP_READ, OP_WRITE, OP_RECALL, OP_STORE, OP_SLEEP, OP_WREN, OP_WRDIS
   } ssnc_op_t;

   // gray coded in listed order: idle -> shift -> read data -> write data -> wait, then the array operations
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SHIFT = 3'h1,
      ST_RDATA = 3'h3,
      ST_WDATA = 3'h2,
      ST_WAITCE = 3'h6,
      ST_STORE = 3'h7,
      ST_RECALL = 3'h5
   } ssnc_state_t;

   // host pins as they arrive
   typedef struct packed {
      logic chipEnable;
      logic serialShiftClock;
      logic serialInLine;
      logic storeReqN;
      logic recallReqN;
   } ssnc_pins_t;

   // one word on its way to the nv array
   typedef struct packed {
      logic [ADDR_BITS-1:0] addr;
      logic [WORD_BITS-1:0] data;
   } ssnc_nvword_t;

endpackage

// ---- logic/ssnc_ctrl.sv ----
// serial shadow nvram control: pin front end, instruction fsm, arrays, store queue

// ---------------------------------------------------------------
// store queue: plain synchronous fifo
// ---------------------------------------------------------------
module ssnc_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 32
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH]; // storage, no reset needed
   logic [AW:0] wrPtr_reg; // extra bit tells full from empty
   logic [AW:0] rdPtr_reg;
   wire logic pushOk = inValid && inReady;
   wire logic popOk = outValid && outReady;
   wire logic ptrLowEq = wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0];

   assign inReady = !(ptrLowEq && (wrPtr_reg[AW] != rdPtr_reg[AW]));
   assign outValid = wrPtr_reg != rdPtr_reg;
   assign outData = mem[rdPtr_reg[AW-1:0]];

   // data write
   always_ff @(posedge clock) begin
      if (pushOk) begin
         mem[wrPtr_reg[AW-1:0]] <= inData;
      end
   end

   // pointers
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
      end else begin
         if (pushOk) begin
            wrPtr_reg <= wrPtr_reg + 1'b1;
         end
         if (popOk) begin
            rdPtr_reg <= rdPtr_reg + 1'b1;
         end
      end
   end
endmodule

// ---------------------------------------------------------------
// top: the device behind its pins
// ---------------------------------------------------------------
module ssnc_ctrl import ssnc_pkg::*; #(
   parameter int STORE_CYCLES = STORE_CYC // self-timed store length
) (
   input wire logic clock,
   input wire logic rstn,
   input wire ssnc_pins_t pinsIn,
   output logic serialOut,
   output logic serialOutEn,
   output logic storeBusy,
   output logic sleepMode,
   output logic standby
);

   // ------------------------------------------------------------
   // opcode decode
   // ------------------------------------------------------------
   function automatic ssnc_op_t decodeOp(input logic [2:0] opc);
      ssnc_op_t res;
      res = OP_WRDIS;
      if (opc[2:1] == OPC_READ_HI) begin
         res = OP_READ; // last bit is the host turnaround slot
      end else begin
         case (opc)
            OPC_WRITE: res = OP_WRITE;
            OPC_RECALL: res = OP_RECALL;
            OPC_STORE: res = OP_STORE;
            OPC_SLEEP: res = OP_SLEEP;
            OPC_WREN: res = OP_WREN;
            default: res = OP_WRDIS;
         endcase
      end
      return res;
   endfunction

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   ssnc_pins_t pinMeta_reg; // first stage, read only by second
   ssnc_pins_t pinSync_reg; // second stage
   logic shiftClkPrev_reg; // last synced shift clock

   genvar gi;
   generate
      for (gi = 0; gi < $bits(ssnc_pins_t); gi++) begin : g_sync
         // only the store and recall pins idle high; chip enable, shift clock and data idle low
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               pinMeta_reg[gi] <= (gi < 2) ? 1'b1 : 1'b0;
               pinSync_reg[gi] <= (gi < 2) ? 1'b1 : 1'b0;
            end else begin
               pinMeta_reg[gi] <= pinsIn[gi];
               pinSync_reg[gi] <= pinMeta_reg[gi];
            end
         end
      end
   endgenerate

   wire logic ceS = pinSync_reg.chipEnable;
   wire logic dinS = pinSync_reg.serialInLine;
   wire logic shiftClkRise = pinSync_reg.serialShiftClock && !shiftClkPrev_reg;
   wire logic recallHw = !pinSync_reg.recallReqN;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   ssnc_state_t state_reg, state_next;
   logic [INSTR_BITS-2:0] instr_reg; // bits after marker, minus the last
   logic [2:0] bitCnt_reg; // instruction bit count
   logic [ADDR_BITS-1:0] bitPtr_reg; // data bit pointer
   logic [ADDR_BITS-1:0] addr_reg; // latched word address
   logic weFlag_reg; // write-enable flag
   logic recalled_reg; // a recall has run since power-up
   logic [7:0] storeLow_reg; // store pin low time
   logic [31:0] storeCnt_reg; // store elapsed cycles
   logic [4:0] pushIdx_reg; // next word to queue
   logic [DRAIN_DIV_BITS-1:0] drainDiv_reg; // nv write pacing
   logic [WORD_BITS-1:0] ram_reg [WORDS]; // volatile array
   logic [WORD_BITS-1:0] nv_reg [WORDS]; // nonvolatile array

   // fifo hookup
   ssnc_nvword_t fifoIn, fifoOut;
   logic fifoInReady, fifoOutValid;

   // ------------------------------------------------------------
   // decode of the instruction and of the priority conditions
   // ------------------------------------------------------------
   wire logic [INSTR_BITS-1:0] instrWord = {instr_reg, dinS};
   wire ssnc_op_t op = decodeOp(instrWord[2:0]);
   wire logic storing = state_reg == ST_STORE;
   // a filtered level, never latched: release undoes the request
   wire logic hwStore = storeLow_reg == STORE_FILT_CYC;
   wire logic writeHold = (state_reg == ST_WDATA) && ceS;
   wire logic storeGate = recalled_reg && weFlag_reg && !sleepMode;
   wire logic hwStoreGo = hwStore && !recallHw && storeGate && !writeHold
                          && !storing && state_reg != ST_RECALL;
   // a pin operation swallows the last bit, so no flag or sleep side effect leaks
   wire logic shiftDone = (state_reg == ST_SHIFT) && shiftClkRise && ceS
                          && bitCnt_reg == INSTR_LAST && !recallHw && !hwStoreGo;
   wire logic swRecall = shiftDone && op == OP_RECALL;
   wire logic swStore = shiftDone && op == OP_STORE && storeGate;
   wire logic storeDone = storing && pushIdx_reg == PUSH_END && !fifoOutValid
                          && storeCnt_reg >= 32'(STORE_CYCLES - 1);
   // whole-array copy into ram, in a single cycle
   wire logic ramLoadNv = (state_reg == ST_RECALL) || swRecall;
   wire logic dataClk = shiftClkRise && ceS && !recallHw && !hwStoreGo;
   wire logic ramWrBit = (state_reg == ST_WDATA) && dataClk;
   wire logic readClk = (state_reg == ST_RDATA) && dataClk;
   wire logic sleepGo = shiftDone && op == OP_SLEEP && !sleepMode;
   wire logic popTick = drainDiv_reg == '0;
   wire logic fifoPush = storing && pushIdx_reg != PUSH_END;

   // ------------------------------------------------------------
   // next state, priority from top to bottom
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      if (storing) begin
         // a running store is never interrupted
         if (storeDone) begin
            state_next = ST_WAITCE;
         end
      end else if (recallHw) begin
         state_next = ST_RECALL;
      end else if (state_reg == ST_RECALL) begin
         state_next = ST_WAITCE;
      end else if (hwStoreGo) begin
         state_next = ST_STORE;
      end else if (!ceS) begin
         state_next = ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               // zeros before the marker are ignored
               if (shiftClkRise && dinS) begin
                  state_next = ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (shiftDone) begin
                  case (op)
                     OP_READ: state_next = sleepMode ? ST_WAITCE : ST_RDATA;
                     OP_WRITE: begin
                        // locked flag: the data is clocked in and dropped
                        if (weFlag_reg && !sleepMode) begin
                           state_next = ST_WDATA;
                        end else begin
                           state_next = ST_WAITCE;
                        end
                     end
                     OP_STORE: state_next = swStore ? ST_STORE : ST_WAITCE;
                     default: state_next = ST_WAITCE;
                  endcase
               end
            end
            // data phases wrap until chip enable falls
            ST_RDATA: state_next = ST_RDATA;
            ST_WDATA: state_next = ST_WDATA;
            ST_WAITCE: state_next = ST_WAITCE;
            default: state_next = ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // state register and instruction shifter
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
         shiftClkPrev_reg <= 1'b0;
         instr_reg <= '0;
         bitCnt_reg <= '0;
         addr_reg <= '0;
      end else begin
         state_reg <= state_next;
         shiftClkPrev_reg <= pinSync_reg.serialShiftClock;
         // only counts in shift; any other state clears it
         if (state_next != ST_SHIFT) begin
            bitCnt_reg <= '0;
            instr_reg <= '0;
         end else if (state_reg == ST_SHIFT && shiftClkRise) begin
            bitCnt_reg <= bitCnt_reg + 1'b1;
            instr_reg <= instrWord[INSTR_BITS-2:0];
         end
         if (shiftDone) begin
            addr_reg <= instrWord[6:3];
         end
      end
   end

   // ------------------------------------------------------------
   // bit pointer: cleared whenever no data phase follows
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bitPtr_reg <= '0;
      end else if (state_next != ST_RDATA && state_next != ST_WDATA) begin
         bitPtr_reg <= '0;
      end else if (readClk || ramWrBit) begin
         bitPtr_reg <= bitPtr_reg + 1'b1; // wraps 15 -> 0
      end
   end

   // ------------------------------------------------------------
   // flags
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         weFlag_reg <= 1'b0;
         recalled_reg <= 1'b0;
         sleepMode <= 1'b0;
      end else begin
         if (storeDone) begin
            weFlag_reg <= 1'b0;
         end else if (shiftDone && op == OP_WREN) begin
            weFlag_reg <= 1'b1;
         end else if (shiftDone && op == OP_WRDIS) begin
            weFlag_reg <= 1'b0;
         end
         if (ramLoadNv) begin
            recalled_reg <= 1'b1;
            sleepMode <= 1'b0;
         end else if (sleepGo) begin
            sleepMode <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // store pin filter: must stay low for the whole filter time
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         storeLow_reg <= '0;
      end else if (pinSync_reg.storeReqN) begin
         storeLow_reg <= '0;
      end else if (storeLow_reg != STORE_FILT_CYC) begin
         storeLow_reg <= storeLow_reg + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // ram array: serial bit write, recall copy, sleep loss
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < WORDS; i++) begin
            ram_reg[i] <= '0;
         end
      end else if (ramLoadNv) begin
         for (int i = 0; i < WORDS; i++) begin
            ram_reg[i] <= nv_reg[i];
         end
      end else if (sleepGo) begin
         for (int i = 0; i < WORDS; i++) begin
            ram_reg[i] <= '0; // contents lost
         end
      end else if (ramWrBit) begin
         // each bit lands at once, so a cut word is partly new
         ram_reg[addr_reg][bitPtr_reg] <= dinS;
      end
   end

   // ------------------------------------------------------------
   // store sequencing: ram words queued, drained at the nv pace
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pushIdx_reg <= '0;
         storeCnt_reg <= '0;
         drainDiv_reg <= '0;
      end else begin
         drainDiv_reg <= drainDiv_reg + 1'b1;
         if (!storing) begin
            pushIdx_reg <= '0;
            storeCnt_reg <= '0;
         end else begin
            if (fifoPush && fifoInReady) begin
               pushIdx_reg <= pushIdx_reg + 1'b1;
            end
            if (storeCnt_reg != 32'(STORE_CYCLES - 1)) begin
               storeCnt_reg <= storeCnt_reg + 1'b1;
            end
         end
      end
   end

   assign fifoIn.addr = pushIdx_reg[ADDR_BITS-1:0];
   assign fifoIn.data = ram_reg[pushIdx_reg[ADDR_BITS-1:0]];

   // the slow drain is what lets the queue back up
   ssnc_fifo #(
      .WIDTH($bits(ssnc_nvword_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .rstn(rstn),
      .inData(fifoIn),
      .inValid(fifoPush),
      .inReady(fifoInReady),
      .outData(fifoOut),
      .outValid(fifoOutValid),
      .outReady(popTick)
   );

   // nv array: written only by the drain side
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < WORDS; i++) begin
            nv_reg[i] <= '0;
         end
      end else if (fifoOutValid && popTick) begin
         nv_reg[fifoOut.addr] <= fifoOut.data;
      end
   end

   // ------------------------------------------------------------
   // outputs, all registered
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         serialOut <= 1'b0;
         serialOutEn <= 1'b0;
         storeBusy <= 1'b0;
         standby <= 1'b1;
      end else begin
         storeBusy <= state_next == ST_STORE;
         standby <= !ceS && state_next != ST_STORE && state_next != ST_RECALL;
         if (readClk) begin
            serialOut <= ram_reg[addr_reg][bitPtr_reg];
            serialOutEn <= 1'b1;
         end else if (state_next != ST_RDATA) begin
            serialOutEn <= 1'b0;
         end
      end
   end

endmodule

// ---- tb/ssnc_ctrl_assertions.sv ----
// concurrent checks on the pins of the serial shadow nvram control top
module ssnc_ctrl_checker import ssnc_pkg::*; #(
   parameter int STORE_CYCLES = STORE_CYC
) (
   input wire logic clock,
   input wire logic rstn,
   input wire ssnc_pins_t pinsIn,
   input wire logic serialOut,
   input wire logic serialOutEn,
   input wire logic storeBusy,
   input wire logic sleepMode,
   input wire logic standby
);
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   int busyCnt; // cycles of the running store
   // counter, since a store is far longer than a repetition
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) busyCnt <= 0;
      else busyCnt <= storeBusy ? busyCnt + 1 : 0;
   end
   sequence ceIdle; // chip enable low long enough to pass the syncs
      !pinsIn.chipEnable [*5];
   endsequence
   sequence clkParked; // shift clock parked, chip enable and recall pin held high
      (pinsIn.chipEnable && pinsIn.recallReqN && $stable(pinsIn.serialShiftClock)) [*8];
   endsequence
   sequence recallHeld; // recall pin low past the syncs
      !pinsIn.recallReqN [*4];
   endsequence
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   busy_hiz_a: assert property (storeBusy |-> !serialOutEn)
      else $error("output driven during store");
   store_time_a: assert property (busyCnt <= STORE_CYCLES + 4)
      else $error("store runs too long");
   store_min_a: assert property ($rose(storeBusy) |-> storeBusy [*8])
      else $error("store ended at once");
   ce_hiz_a: assert property (ceIdle |-> !serialOutEn)
      else $error("output driven with chip enable low");
   ce_standby_a: assert property (
      (!pinsIn.chipEnable && pinsIn.recallReqN && pinsIn.storeReqN && !storeBusy) [*8]
      |-> standby) else $error("standby missing");
   read_hold_a: assert property (
      (clkParked ##0 serialOutEn) |-> $stable(serialOut))
      else $error("read bit moved without a shift clock");
   recall_wins_a: assert property (recallHeld |-> !$rose(storeBusy))
      else $error("store began under recall");
   sleep_quiet_a: assert property (sleepMode |-> !storeBusy && !serialOutEn)
      else $error("activity in sleep");
endmodule

bind ssnc_ctrl ssnc_ctrl_checker #(.STORE_CYCLES(STORE_CYCLES)) chk_u (.clock(clock),
   .rstn(rstn), .pinsIn(pinsIn), .serialOut(serialOut), .serialOutEn(serialOutEn),
   .storeBusy(storeBusy), .sleepMode(sleepMode), .standby(standby));

// ---- tb/ssnc_host.sv ----
// host port model: bit-banged chip enable, shift clock, data and hardware pins
module ssnc_host import ssnc_pkg::*; (
   input wire logic clock,
   input wire logic serialOut,
   input wire logic serialOutEn,
   output ssnc_pins_t pinsOut
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle pins from time zero
   initial pinsOut = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
   // every change lands just after an edge
   task automatic waitCyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // one shift clock period, 4 cycles per level covers the 2 cycle sync
   task automatic clkBit(input logic d, output logic q);
      pinsOut.serialInLine = d;
      waitCyc(4);
      pinsOut.serialShiftClock = 1'b1;
      waitCyc(4);
      pinsOut.serialShiftClock = 1'b0;
      waitCyc(4);
      q = serialOutEn ? serialOut : 1'bz; // undriven pin never reads as data
   endtask
   task automatic ceLow;
      pinsOut.chipEnable = 1'b0;
      waitCyc(6);
   endtask
   // ce cycles before each instruction, a leading zero, marker, msb first
   task automatic instr(input logic [3:0] a, input logic [2:0] op);
      logic q;
      ceLow();
      pinsOut.chipEnable = 1'b1;
      waitCyc(4);
      clkBit(1'b0, q);
      clkBit(1'b1, q);
      for (int i = 3; i >= 0; i--) clkBit(a[i], q);
      for (int i = 2; i >= 0; i--) clkBit(op[i], q);
   endtask
   // n data clocks, lsb first, repeating the word
   task automatic xfer(input int n, input logic [15:0] wd, output logic [31:0] rd);
      rd = '0;
      for (int k = 0; k < n; k++) clkBit(wd[k % 16], rd[k]);
   endtask
   task automatic setPins(input logic stN, input logic rcN);
      pinsOut.storeReqN = stN;
      pinsOut.recallReqN = rcN;
   endtask
endmodule

// ---- tb/tb_ssnc_ctrl.sv ----
// self-checking bench for the serial shadow nvram control top
module tb_ssnc_ctrl import ssnc_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int STC = 2000; // short store so the run stays brief
   logic clock;
   logic rstn;
   ssnc_pins_t pinsIn;
   logic serialOut, serialOutEn, storeBusy, sleepMode, standby;
   int n_mismatch = 0;
   int checks = 0;
   logic [31:0] rd; // last read-back
   // ---------------------------------------------
   // clock, design and host
   // ---------------------------------------------
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   ssnc_ctrl #(.STORE_CYCLES(STC)) dut_u (.clock(clock), .rstn(rstn), .pinsIn(pinsIn),
      .serialOut(serialOut), .serialOutEn(serialOutEn), .storeBusy(storeBusy),
      .sleepMode(sleepMode), .standby(standby));
   ssnc_host host_u (.clock(clock), .serialOut(serialOut), .serialOutEn(serialOutEn),
      .pinsOut(pinsIn));
   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // bounded wait on the store flag
   task automatic waitBusy(input logic lvl, input int bound);
      for (int i = 0; i < bound && storeBusy !== lvl; i++) host_u.waitCyc(1);
      chk("storeBusy wait", {31'h0, lvl}, {31'h0, storeBusy});
      if (storeBusy !== lvl) complete_run();
   endtask
   task automatic op(input logic [2:0] code);
      host_u.instr(4'h0, code);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d, input int n);
      host_u.instr(a, OPC_WRITE);
      host_u.xfer(n, d, rd);
   endtask
   // two passes over the word, so wrap is seen
   task automatic rdWord(input logic [3:0] a, input logic lsb);
      host_u.instr(a, {OPC_READ_HI, lsb});
      host_u.xfer(32, 16'h0, rd);
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic tGuard;
      wr(4'h3, 16'ha5a5, 16);
      rdWord(4'h3, 1'b0);
      chk("unflagged write", 32'h0, rd);
      op(OPC_WREN);
      op(OPC_STORE);
      host_u.waitCyc(40);
      chk("store before recall", 32'h0, {31'h0, storeBusy});
      op(OPC_WRDIS);
      wr(4'h3, 16'h5a5a, 16);
      rdWord(4'h3, 1'b0);
      chk("disabled write", 32'h0, rd);
      op(OPC_WREN);
      $display("test guard done");
   endtask
   task automatic tReadWrite;
      wr(4'h2, 16'h1234, 16);
      rdWord(4'h2, 1'b0);
      chk("word wrap", 32'h12341234, rd);
      wr(4'h2, 16'hffff, 4);
      rdWord(4'h2, 1'b1);
      chk("cut write", 32'h123f123f, rd);
      // park the shift clock mid-word, then carry on where it stopped
      host_u.instr(4'h2, {OPC_READ_HI, 1'b0});
      host_u.xfer(4, 16'h0, rd);
      host_u.waitCyc(20);
      chk("parked read", 32'h3, {29'h0, standby, serialOutEn, serialOut});
      host_u.xfer(4, 16'h0, rd);
      chk("resumed read", 32'h3, rd);
      $display("test read write done");
   endtask
   task automatic tStoreSleep;
      op(OPC_RECALL);
      rdWord(4'h2, 1'b0);
      chk("recall zero", 32'h0, rd);
      op(OPC_WREN);
      wr(4'h2, 16'hbeef, 16);
      op(OPC_STORE);
      waitBusy(1'b1, 20);
      chk("store hi-z", 32'h0, {31'h0, serialOutEn});
      waitBusy(1'b0, STC + 200);
      wr(4'h2, 16'h0, 16);
      rdWord(4'h2, 1'b0);
      chk("flag after store", 32'hbeefbeef, rd);
      op(OPC_SLEEP);
      host_u.ceLow();
      chk("sleep", 32'h1, {31'h0, sleepMode});
      chk("standby", 32'h1, {31'h0, standby});
      op(OPC_RECALL);
      host_u.ceLow();
      chk("wake", 32'h0, {31'h0, sleepMode});
      rdWord(4'h2, 1'b0);
      chk("wake data", 32'hbeefbeef, rd);
      $display("test store sleep done");
   endtask
   task automatic tHardware;
      op(OPC_WREN);
      wr(4'h2, 16'h5555, 16);
      host_u.ceLow();
      host_u.setPins(1'b0, 1'b0);
      host_u.waitCyc(40);
      chk("store under recall", 32'h0, {31'h0, storeBusy});
      host_u.setPins(1'b1, 1'b0);
      host_u.waitCyc(4);
      host_u.setPins(1'b1, 1'b1);
      rdWord(4'h2, 1'b0);
      chk("pin recall", 32'hbeefbeef, rd);
      host_u.ceLow();
      host_u.setPins(1'b0, 1'b1);
      host_u.waitCyc(10);
      host_u.setPins(1'b1, 1'b1);
      host_u.waitCyc(10);
      chk("store glitch", 32'h0, {31'h0, storeBusy});
      host_u.setPins(1'b0, 1'b1);
      waitBusy(1'b1, 60);
      host_u.setPins(1'b1, 1'b1);
      waitBusy(1'b0, STC + 200);
      op(OPC_WREN);
      wr(4'h1, 16'h00ff, 8);
      host_u.setPins(1'b0, 1'b1);
      host_u.xfer(4, 16'h0, rd);
      chk("store held off", 32'h0, {31'h0, storeBusy});
      host_u.ceLow();
      waitBusy(1'b1, 60);
      host_u.setPins(1'b1, 1'b1);
      waitBusy(1'b0, STC + 200);
      $display("test hardware done");
   endtask
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      rstn = 1'b0;
      repeat (3) @(posedge clock);
      #1;
      chk("reset outputs", 32'h1, {28'h0, serialOutEn, storeBusy, sleepMode, standby});
      rstn = 1'b1;
      host_u.waitCyc(4);
      tGuard();
      tReadWrite();
      tStoreSleep();
      tHardware();
      complete_run();
   end
endmodule
